// file: logic/smfs_cfg.svh
// Constants for the switch mode and fault supervisor
`ifndef SMFS_CFG_SVH
`define SMFS_CFG_SVH
// ==========================================
// Command word layout
`define SMFS_CMD_BITS 8
`define SMFS_WD_BIT 7
// ==========================================
// Fault word layout
`define SMFS_FLT_OT 0
`define SMFS_FLT_OV 1
`define SMFS_FLT_UV 2
`define SMFS_FLT_OL 3
`define SMFS_FLT_OC 4
`define SMFS_FLT_FSI 5
`define SMFS_FLT_WATCHDOG_EXPIRED_FLAG 6
// ==========================================
// Reset values of over-current settings
`define SMFS_OCL_DEF 3'h0
`define SMFS_OCH_DEF 1'h0
`define SMFS_OCT_DEF 2'h0
// ==========================================
// Watchdog timing
`define SMFS_OSC_DIV 8'd125
`define SMFS_WD_UNIT_US 1
`define SMFS_WD_TICKS 16'd20
`endif

// file: logic/smfs_pkg.sv
// Types for the switch mode and fault supervisor
package smfs_pkg;
	typedef enum logic [3:0] {
		SMFS_SLEEP = 4'b0001,
		SMFS_NORMAL = 4'b0010,
		SMFS_FAULT = 4'b0100,
		SMFS_FAILSAFE = 4'b1000
	} smfs_mode_t;
	typedef enum logic [1:0] {
		SMFS_FSR_GND = 2'h0,
		SMFS_FSR_OFF = 2'h1,
		SMFS_FSR_ON = 2'h2
	} smfs_fsr_t;
endpackage : smfs_pkg

// file: logic/smfs_supervisor.sv
// Mode, watchdog and fault supervisor of a high-side switch
// Behaviour
// R1: Wake and reset low give Sleep, outputs off
// R2: Sleep treats every setting as zero
// R3: Reset high, battery good, no fault: Normal
// R4: Rising wake or reset arms watchdog
// R5: Host toggles watchdog bit every command
// R6: Changed watchdog bit restarts the timeout
// R7: Timeout enters latched Fail-safe
// R8: Fail-safe output follows select resistor
// R9: Fail-safe restores over-current defaults only
// R10: Watchdog expired flag reads one in Fail-safe
// R11: Wake and reset falling together leave Fail-safe
// R12: Grounded select disables watchdog Fail-safe
// R13: Logic supply loss resets registers, direct drive
// R14: Any fault pulls fault pin low
// R15: Fault pin releases when faults clear
// R16: Fault word shifted out, cleared by transfer
// R17: Over-temperature checked only while on
// R18: Over-temperature flag cleared by read
// R19: Over-voltage holds output off, sets flag
// R20: Over-voltage protection can be disabled
// R21: Under-voltage turns off, sets pin and flag
// R22: Recovery with command low releases pin
// R23: Recovery with command on keeps pin low
// R24: Under-voltage disable hides it to floor
// R25: Commands MSB first, sampled on rising clock
`timescale 1ns/1ps
`include "smfs_cfg.svh"
module smfs_supervisor import smfs_pkg::*; (
	input wire logic core_clk_i, // 125 MHz clock
	input wire logic nrst_i, // Async reset, power-on
	input wire logic wake_i, // Wake pin
	input wire logic rst_n_i, // Device reset pin
	input wire logic [1:0] failsafe_select_resistor_i, // Decoded select resistor
	input wire logic logic_supply_ok_i, // Logic supply in range
	input wire logic direct_in_i, // Direct control input
	input wire logic bat_low_i, // Battery below battery_low_threshold
	input wire logic bat_floor_i, // Battery below 2.5 V floor
	input wire logic overvolt_i, // Over-voltage seen
	input wire logic overtemp_i, // Over-temperature above hysteresis
	input wire logic openload_i, // Open load seen
	input wire logic overcurrent_i, // Over-current trip seen
	input wire logic sclk_i, // Serial clock pin
	input wire logic cs_n_i, // Chip select pin
	input wire logic si_i, // Serial data in pin
	output logic so_o, // Serial data out
	output logic so_oe_n_o, // Serial out enable, low drives
	output logic out_on_o, // Output switch command
	output logic fault_flag_n_o, // Fault pin level
	output logic fault_flag_n_oe_n_o, // Fault pin pull enable, low pulls
	output logic [3:0] mode_o, // Current mode
	output logic [7:0] cfg_o, // Last command word in effect
	output logic [2:0] overcurrent_low_level_o, // Low trip level
	output logic overcurrent_high_level_o, // High trip level
	output logic [1:0] overcurrent_low_time_o, // Low trip time
	output logic watchdog_expired_flag_o, // Watchdog expired flag
	output logic [7:0] fault_word_o // Latched fault word
);
	// ==========================================
	// Pin synchronisers
	localparam int NSYNC = 11;
	logic [NSYNC-1:0] s1, s2;
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			// Chip select resets to its idle high level so reset shows no selection
			s1 <= 11'h002;
			s2 <= 11'h002;
		end else begin
			s1 <= {wake_i, rst_n_i, failsafe_select_resistor_i, logic_supply_ok_i, bat_low_i,
				bat_floor_i, overvolt_i, sclk_i, cs_n_i, si_i};
			s2 <= s1;
		end
	end
	logic wake, rstn, vdd_ok, bl, bfl, ovs, sck, csn, sin;
	logic [1:0] fsr;
	assign {wake, rstn, fsr, vdd_ok, bl, bfl, ovs, sck, csn, sin} = s2;
	logic [3:0] a1, a2;
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			a1 <= '0;
			a2 <= '0;
		end else begin
			a1 <= {overtemp_i, openload_i, overcurrent_i, direct_in_i};
			a2 <= a1;
		end
	end
	logic otp, olp, ocp, din;
	assign {otp, olp, ocp, din} = a2;
	logic wake_q, rstn_q, sck_q, csn_q;
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wake_q <= 1'b0;
			rstn_q <= 1'b0;
			sck_q <= 1'b0;
			csn_q <= 1'b1;
		end else begin
			wake_q <= wake;
			rstn_q <= rstn;
			sck_q <= sck;
			csn_q <= csn;
		end
	end
	wire arm_ev = (wake & ~wake_q) | (rstn & ~rstn_q);
	wire both_fall = wake_q & rstn_q & ~wake & ~rstn;
	wire sleep_req = ~wake & ~rstn;
	wire fs_gnd = (fsr == SMFS_FSR_GND);
	wire clr_all = ~vdd_ok | sleep_req;
	// ==========================================
	// Serial command shifter
	logic [7:0] shreg;
	logic [2:0] bitcnt;
	logic xfer_done;
	logic [7:0] so_word;
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			shreg <= 8'h00;
			bitcnt <= 3'h0;
			xfer_done <= 1'b0;
		end else begin
			xfer_done <= 1'b0;
			if (csn) begin
				bitcnt <= 3'h0;
			end else if (sck & ~sck_q) begin
				shreg <= {shreg[6:0], sin}; // R25
				bitcnt <= bitcnt + 3'h1;
				if (bitcnt == 3'h7) begin
					xfer_done <= 1'b1;
				end
			end
		end
	end
	// SO shifts out the fault word captured at chip select fall
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			so_word <= 8'h00;
		end else if (csn_q & ~csn) begin
			so_word <= fault_word_o; // R16
		end else if (~csn & sck & ~sck_q) begin
			so_word <= {so_word[6:0], 1'b0};
		end
	end
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			so_o <= 1'b0;
			so_oe_n_o <= 1'b1;
		end else begin
			so_o <= so_word[7];
			so_oe_n_o <= csn;
		end
	end
	// ==========================================
	// Configuration
	// Power loss and Sleep both zero the settings; Fail-safe restores only the
	// over-current group so the rest of the setup survives a host crash.
	logic wd_prev;
	logic wd_serviced;
	logic failsafe;
	logic failsafe_q;
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cfg_o <= 8'h00;
			wd_prev <= 1'b0;
			wd_serviced <= 1'b0;
		end else begin
			wd_serviced <= 1'b0;
			if (clr_all) begin
				cfg_o <= 8'h00; // R2 R13
				wd_prev <= 1'b0;
			end else if (xfer_done) begin
				cfg_o <= shreg;
				wd_prev <= shreg[`SMFS_WD_BIT];
				if (shreg[`SMFS_WD_BIT] != wd_prev) begin
					wd_serviced <= 1'b1; // R6
				end
			end
		end
	end
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			overcurrent_low_level_o <= `SMFS_OCL_DEF;
			overcurrent_high_level_o <= `SMFS_OCH_DEF;
			overcurrent_low_time_o <= `SMFS_OCT_DEF;
		end else if (clr_all || (failsafe && !failsafe_q)) begin
			overcurrent_low_level_o <= `SMFS_OCL_DEF; // R9
			overcurrent_high_level_o <= `SMFS_OCH_DEF;
			overcurrent_low_time_o <= `SMFS_OCT_DEF;
		end else if (xfer_done && !failsafe) begin
			overcurrent_low_level_o <= shreg[2:0];
			overcurrent_high_level_o <= shreg[3];
			overcurrent_low_time_o <= shreg[5:4];
		end
	end
	wire overvolt_disable = cfg_o[6]; // overvolt_disable
	wire undervolt_disable = cfg_o[5]; // undervolt_disable
	wire out_cmd = cfg_o[0] | din;
	// ==========================================
	// Watchdog
	logic [7:0] div;
	logic tick;
	logic [15:0] wdcnt;
	logic armed;
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			div <= 8'h00;
			tick <= 1'b0;
		end else begin
			tick <= (div == `SMFS_OSC_DIV - 8'd1);
			div <= (div == `SMFS_OSC_DIV - 8'd1) ? 8'h00 : div + 8'h01;
		end
	end
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			armed <= 1'b0;
		end else if (fs_gnd || clr_all) begin
			armed <= 1'b0; // R12
		end else if (arm_ev) begin
			armed <= 1'b1; // R4
		end
	end
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wdcnt <= 16'h0000;
		end else if (!armed || wd_serviced || arm_ev) begin
			wdcnt <= 16'h0000; // R6
		end else if (tick && wdcnt != `SMFS_WD_TICKS) begin
			wdcnt <= wdcnt + 16'h0001;
		end
	end
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			failsafe <= 1'b0;
			failsafe_q <= 1'b0;
		end else begin
			failsafe_q <= failsafe;
			if (both_fall || fs_gnd || ~vdd_ok) begin
				failsafe <= 1'b0; // R11 R12
			end else if (armed && wdcnt == `SMFS_WD_TICKS) begin
				failsafe <= 1'b1; // R7
			end
		end
	end
	assign watchdog_expired_flag_o = failsafe; // R10
	// ==========================================
	// Protection and fault flags
	logic ot_flag, ov_flag, uv_flag, ol_flag, oc_flag;
	logic ot_hold, oc_latch, uv_latch;
	wire uv_now = bl & ~undervolt_disable;
	wire ov_now = ovs & ~overvolt_disable; // R20
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ot_hold <= 1'b0;
			oc_latch <= 1'b0;
			uv_latch <= 1'b0;
		end else begin
			if (otp && out_on_o) begin
				ot_hold <= 1'b1; // R17
			end else if (!otp) begin
				ot_hold <= 1'b0;
			end
			if (ocp) begin
				oc_latch <= 1'b1;
			end else if (!out_cmd) begin
				oc_latch <= 1'b0;
			end
			if (uv_now && out_cmd) begin
				uv_latch <= 1'b1; // R23
			end else if (!out_cmd || undervolt_disable) begin
				uv_latch <= 1'b0; // R22
			end
		end
	end
	// Hardware set wins over the read clear
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ot_flag <= 1'b0;
			ov_flag <= 1'b0;
			uv_flag <= 1'b0;
			ol_flag <= 1'b0;
			oc_flag <= 1'b0;
		end else if (~vdd_ok) begin
			ot_flag <= 1'b0;
			ov_flag <= 1'b0;
			uv_flag <= 1'b0;
			ol_flag <= 1'b0;
			oc_flag <= 1'b0;
		end else begin
			ot_flag <= (otp & out_on_o) | (ot_flag & ~xfer_done); // R17 R18
			ov_flag <= ov_now | (ov_flag & ~xfer_done); // R19
			uv_flag <= uv_now | (uv_flag & ~xfer_done); // R21 R22
			ol_flag <= olp | (ol_flag & ~xfer_done); // R16
			oc_flag <= oc_latch | (oc_flag & ~xfer_done);
		end
	end
	assign fault_word_o = {1'b0, failsafe, ~fs_gnd, oc_flag, ol_flag, uv_flag, ov_flag, ot_flag};
	wire fault_now = ot_hold | ov_now | uv_now | olp | oc_latch | uv_latch; // R14 R15
	wire fault_off = ot_hold | ov_now | uv_now | oc_latch | uv_latch | (bfl & ~undervolt_disable);
	// ==========================================
	// Mode and output
	smfs_mode_t mode;
	always_comb begin
		if (sleep_req) begin
			mode = SMFS_SLEEP; // R1
		end else if (failsafe) begin
			mode = SMFS_FAILSAFE;
		end else if (fault_now) begin
			mode = SMFS_FAULT;
		end else begin
			mode = SMFS_NORMAL; // R3
		end
	end
	assign mode_o = mode;
	logic next_out;
	always_comb begin
		next_out = 1'b0;
		unique case (mode)
			SMFS_SLEEP: next_out = 1'b0; // R1
			SMFS_FAILSAFE: next_out = (fsr == SMFS_FSR_ON) & ~fault_off; // R8
			SMFS_FAULT,
			SMFS_NORMAL: next_out = out_cmd & ~fault_off & ~bfl; // R24
		endcase
		if (!vdd_ok) begin
			next_out = din & ~fault_off; // R13
		end
	end
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			out_on_o <= 1'b0;
			fault_flag_n_o <= 1'b0;
			fault_flag_n_oe_n_o <= 1'b1;
		end else begin
			out_on_o <= next_out;
			fault_flag_n_oe_n_o <= ~fault_now; // R14
		end
	end
	// ==========================================
	// Checks
	a_sleep_off: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // R1
		mode == SMFS_SLEEP && vdd_ok |=> !out_on_o) else $error("output on in sleep");
	a_watchdog_expired_flag_flag: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // R10
		watchdog_expired_flag_o == (mode == SMFS_FAILSAFE || (failsafe && sleep_req)))
		else $error("expired flag mismatch");
	a_gnd_nofs: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // R12
		fs_gnd |=> !failsafe) else $error("failsafe with grounded select");
	sequence s_both_fall;
		failsafe ##0 both_fall;
	endsequence
	a_fs_exit: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // R11
		s_both_fall |=> !failsafe) else $error("failsafe not left");
	a_fs_out: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // R8
		mode == SMFS_FAILSAFE && fsr == SMFS_FSR_OFF && vdd_ok |=> !out_on_o)
		else $error("failsafe off violated");
	a_fs_defaults: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // R9
		failsafe && !failsafe_q |=> overcurrent_low_level_o == `SMFS_OCL_DEF &&
		overcurrent_high_level_o == `SMFS_OCH_DEF && overcurrent_low_time_o == `SMFS_OCT_DEF)
		else $error("over-current settings kept in failsafe");
	a_fault_pin: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // R14
		ov_now |=> !fault_flag_n_oe_n_o && !out_on_o) else $error("ov not reported");
	a_ov_flag: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // R19
		ov_now && vdd_ok |=> fault_word_o[`SMFS_FLT_OV]) else $error("ov flag missing");
	a_undervolt_disable: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // R24
		undervolt_disable && bl && !bfl && out_cmd && vdd_ok && mode == SMFS_NORMAL |=> out_on_o)
		else $error("output dropped with undervolt disabled");
	a_wd_timeout: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // R7
		armed && wdcnt == `SMFS_WD_TICKS && !both_fall && !fs_gnd && vdd_ok |=> failsafe)
		else $error("timeout missed");
	a_read_clear: assert property (@(posedge core_clk_i) disable iff (!nrst_i) // R18
		xfer_done && vdd_ok && !otp |=> !ot_flag) else $error("ot flag not cleared");
endmodule : smfs_supervisor

// file: tb/smfs_host.sv
// Host model: serial master that services the watchdog bit
`timescale 1ns/1ps
module smfs_host (
	input wire logic clk_i, // Core clock
	input wire logic so_i, // Serial data from device
	input wire logic so_oe_n_i, // Low while device drives
	output logic sclk_o, // Serial clock, idle low
	output logic cs_n_o, // Chip select
	output logic si_o // Serial data to device
);
	logic wd = 1'b0;
	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		si_o = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(negedge clk_i);
	endtask : tick
	// ==========================================
	// One command; clock phases of six core cycles leave margin over the minimum of four
	task automatic xfer(input logic [6:0] c, output logic [7:0] sent, output logic [7:0] rx);
		wd = ~wd;
		sent = {wd, c};
		cs_n_o = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			si_o = sent[i];
			tick(6);
			// A released line shows the inverse, so a missing drive cannot pass
			rx[i] = so_oe_n_i ? ~so_i : so_i;
			sclk_o = 1'b1;
			tick(6);
			sclk_o = 1'b0;
		end
		tick(6);
		cs_n_o = 1'b1;
		tick(10);
	endtask : xfer
endmodule : smfs_host

// file: tb/smfs_supervisor_tb.sv
// Self-checking bench for the mode and fault supervisor
`timescale 1ns/1ps
module smfs_supervisor_tb import smfs_pkg::*; ;
	typedef struct {int sel; logic [7:0] val;} smfs_note_t;
	logic core_clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic wake = 1'b0;
	logic rst_n = 1'b0;
	logic [1:0] fsr = 2'h0;
	logic supply_ok = 1'b1;
	logic direct_in = 1'b0;
	logic bat_floor = 1'b0;
	logic [4:0] flt = 5'h0;
	logic sclk, cs_n, si, so, so_oe_n, out_on, flt_n, flt_oe_n, wdx, och;
	logic [3:0] mode;
	logic [7:0] cfg, fword, sent, rx;
	logic [2:0] ocl;
	logic [1:0] oct;
	logic [7:0] seed = 8'h5b;
	// Open-drain fault pin with its external pull-up
	wire logic pin = flt_oe_n ? 1'b1 : flt_n;
	int errors = 0;
	int comparisons = 0;
	int cycles = 0;
	smfs_note_t notes[$];
	event chk_ev;
	always #4 core_clk_i = ~core_clk_i;
	smfs_supervisor dut (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .wake_i(wake), .rst_n_i(rst_n),
		.failsafe_select_resistor_i(fsr), .logic_supply_ok_i(supply_ok), .direct_in_i(direct_in),
		.bat_low_i(flt[2]), .bat_floor_i(bat_floor), .overvolt_i(flt[1]), .overtemp_i(flt[0]),
		.openload_i(flt[3]), .overcurrent_i(flt[4]), .sclk_i(sclk), .cs_n_i(cs_n), .si_i(si),
		.so_o(so), .so_oe_n_o(so_oe_n), .out_on_o(out_on), .fault_flag_n_o(flt_n),
		.fault_flag_n_oe_n_o(flt_oe_n), .mode_o(mode), .cfg_o(cfg),
		.overcurrent_low_level_o(ocl), .overcurrent_high_level_o(och),
		.overcurrent_low_time_o(oct), .watchdog_expired_flag_o(wdx), .fault_word_o(fword));
	smfs_host host (.clk_i(core_clk_i), .so_i(so), .so_oe_n_i(so_oe_n), .sclk_o(sclk),
		.cs_n_o(cs_n), .si_o(si));
	// ==========================================
	// Checking
	function automatic logic [7:0] seen(input int sel);
		case (sel)
			0: return rx;
			1: return cfg;
			2: return fword;
			3: return {mode, pin, out_on, wdx, so_oe_n};
			4: return {ocl, och, oct, 2'h0};
			default: return {6'h0, pin, out_on};
		endcase
	endfunction : seen
	always @(chk_ev) begin : monitor
		smfs_note_t n;
		while (notes.size() > 0) begin
			n = notes.pop_front();
			comparisons++;
			if (seen(n.sel) !== n.val) begin
				errors++;
				$display("wrong value at %0t: got %h expected %h", $time, seen(n.sel), n.val);
			end
		end
	end
	task automatic end_of_test();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : end_of_test
	always @(posedge core_clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			errors++;
			end_of_test();
		end
	end
	// ==========================================
	// Stimulus helpers
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr
	task automatic tick(input int n);
		repeat (n) @(negedge core_clk_i);
	endtask : tick
	task automatic note(input int sel, input logic [7:0] val);
		notes.push_back('{sel, val});
	endtask : note
	task automatic look();
		-> chk_ev;
		#1;
	endtask : look
	task automatic send(input logic [6:0] c, input logic [7:0] exp_rx, input logic awake);
		host.xfer(c, sent, rx);
		if (awake) note(0, exp_rx);
		note(1, awake ? sent : 8'h00);
		note(4, awake ? {sent[2:0], sent[3], sent[5:4], 2'h0} : 8'h00);
		look();
	endtask : send
	task automatic state(input logic [3:0] m, input logic p, input logic o);
		note(3, {m, p, o, 2'b01});
		look();
	endtask : state
	// ==========================================
	// Main sequence; table entries are command, fault index, hidden, latched
	logic [15:0] tab [9] = '{16'h0100, 16'h0002, 16'h0110, 16'h4112, 16'h0020,
		16'h0121, 16'h2122, 16'h0030, 16'h0141};
	initial begin
		logic [6:0] c;
		logic [3:0] k;
		logic h, l;
		logic [7:0] w, v;
		tick(6);
		nrst_i = 1'b1;
		tick(4);
		state(SMFS_SLEEP, 1'b1, 1'b0);
		send(7'h01, 8'h00, 1'b0);
		state(SMFS_SLEEP, 1'b1, 1'b0);
		fsr = SMFS_FSR_OFF;
		rst_n = 1'b1;
		wake = 1'b1;
		tick(6);
		state(SMFS_NORMAL, 1'b1, 1'b0);
		for (int i = 0; i < 6; i++) begin
			seed = lfsr(seed);
			send(seed[6:0], 8'h20, 1'b1);
		end
		send(7'h00, 8'h20, 1'b1);
		foreach (tab[i]) begin
			c = tab[i][14:8];
			k = tab[i][7:4];
			h = tab[i][1];
			l = tab[i][0];
			w = h ? 8'h20 : 8'h20 | (8'h01 << k);
			// Over-current flag is set again by its latch until the output is commanded off
			v = (k == 4'h4) ? w : 8'h20;
			send(c, 8'h20, 1'b1);
			flt[k] = 1'b1;
			tick(6);
			state(h ? SMFS_NORMAL : SMFS_FAULT, h, h & c[0]);
			flt[k] = 1'b0;
			tick(6);
			note(2, w);
			state(l ? SMFS_FAULT : SMFS_NORMAL, ~l, ~l & c[0]);
			send(c, w, 1'b1);
			send(7'h00, v, 1'b1);
			send(7'h01, v, 1'b1);
			state(SMFS_NORMAL, 1'b1, 1'b1);
			send(7'h00, 8'h20, 1'b1);
		end
		// ==========================================
		// Watchdog left unserviced: Fail-safe, then both exits
		send(7'h3e, 8'h20, 1'b1);
		tick(2800);
		note(3, {SMFS_FAILSAFE, 1'b1, 1'b0, 2'b11});
		note(4, 8'h00);
		look();
		host.xfer(7'h01, sent, rx);
		note(0, 8'h60);
		note(1, sent);
		note(4, 8'h00);
		note(5, 8'h02);
		look();
		fsr = SMFS_FSR_ON;
		tick(6);
		note(5, 8'h03);
		look();
		wake = 1'b0;
		rst_n = 1'b0;
		tick(6);
		state(SMFS_SLEEP, 1'b1, 1'b0);
		rst_n = 1'b1;
		wake = 1'b1;
		tick(2800);
		note(3, {SMFS_FAILSAFE, 1'b1, 1'b1, 2'b11});
		look();
		fsr = SMFS_FSR_GND;
		tick(6);
		state(SMFS_NORMAL, 1'b1, 1'b0);
		fsr = SMFS_FSR_OFF;
		tick(4);
		send(7'h21, 8'h20, 1'b1);
		flt[2] = 1'b1;
		tick(6);
		note(5, 8'h03);
		look();
		bat_floor = 1'b1;
		tick(6);
		note(5, 8'h02);
		look();
		flt[2] = 1'b0;
		bat_floor = 1'b0;
		tick(6);
		supply_ok = 1'b0;
		direct_in = 1'b1;
		tick(6);
		note(1, 8'h00);
		note(5, 8'h03);
		look();
		direct_in = 1'b0;
		tick(4);
		note(5, 8'h02);
		look();
		supply_ok = 1'b1;
		tick(4);
		wake = 1'b0;
		rst_n = 1'b0;
		tick(6);
		state(SMFS_SLEEP, 1'b1, 1'b0);
		note(1, 8'h00);
		look();
		end_of_test();
	end
endmodule : smfs_supervisor_tb
